// *** shared/reset_init_pkg.sv ***
// Shared constants, carriers and initial-value tables of the reset block.
package reset_init_pkg;

   // Bus geometry.
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;

   // Register offsets, byte addresses.
   localparam logic [ADR_W-1:0] OFS_FLAGS     = 8'h00;
   localparam logic [ADR_W-1:0] OFS_RSTFLAG   = 8'h04;
   localparam logic [ADR_W-1:0] OFS_IRQ_STAT  = 8'h08;
   localparam logic [ADR_W-1:0] OFS_IRQ_MASK  = 8'h0C;
   localparam logic [ADR_W-1:0] OFS_CTRL      = 8'h10;
   localparam logic [ADR_W-1:0] OFS_CORE_BASE = 8'h40;

   // Field positions.
   localparam int FLAG_TO_BIT  = 0;
   localparam int FLAG_PD_BIT  = 1;
   localparam int LOW_VOLTAGE_RESET_FLAG_BIT     = 2;
   localparam int WDT_CLR_BIT  = 0;
   localparam int DATA_LANE    = 0;

   // Managed core registers, one byte each.
   localparam int NREG        = 10;
   localparam int IDX_PC_LOW  = 0;
   localparam int IDX_SP      = 1;
   localparam int IDX_INT     = 2;
   localparam int IDX_TIMER   = 3;
   localparam int IDX_PA      = 4;
   localparam int IDX_PA_DIR  = 5;
   localparam int IDX_PB      = 6;
   localparam int IDX_PB_DIR  = 7;
   localparam int IDX_PC      = 8;
   localparam int IDX_PC_DIR  = 9;

   // Default counter widths.
   localparam int WDT_W_DEF = 18;
   localparam int TB_W_DEF  = 16;

   // Reset requests as they arrive from the reset sources.
   typedef struct packed {
      logic idle;   // Core is in idle or sleep mode.
      logic wdt;    // Watchdog time-out.
      logic low_voltage_reset;    // Low-voltage reset.
      logic por;    // Power-on reset.
   } reset_req_t;

   // One-hot chosen cause; the interrupt status and mask share it.
   typedef struct packed {
      logic wdt_idle;
      logic wdt_run;
      logic low_voltage_reset;
      logic por;
   } cause_t;

   // Flags of the core status register.
   typedef struct packed {
      logic powerdown_flag;
      logic timeout_flag;
   } core_flags_t;

   typedef logic [NREG-1:0][7:0] reg_image_t;

   localparam logic [7:0] SP_TOP    = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Forced values, listed from index 9 down to index 0.
   localparam reg_image_t INIT_VAL = {8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
                                      8'hFF, 8'h00, 8'h00, SP_TOP, 8'h00};
   // Bits kept by an idle or sleep watchdog time-out.
   localparam reg_image_t KEEP_IDLE = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                       8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
   // Implemented bits; port C has no bit 7.
   localparam reg_image_t IMPL_MASK = {8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
                                       8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

endpackage

// *** hdl/reset_cause_pick.sv ***
// Priority choice of the reset cause that selects the initial values.
`timescale 1ns/1ns
module reset_cause_pick (
   input  reset_init_pkg::reset_req_t req,    // Raw reset requests.
   output reset_init_pkg::cause_t     cause   // One-hot chosen cause.
);
   import reset_init_pkg::*;

   // Power-on beats low-voltage, which beats the watchdog.
   // The low-voltage detector is off in idle or sleep mode.
   always_comb begin
      cause = '0;
      if (req.por) begin
         cause.por = 1'b1;
      end else if (req.low_voltage_reset && !req.idle) begin
         cause.low_voltage_reset = 1'b1;
      end else if (req.wdt) begin
         cause.wdt_idle = req.idle;
         cause.wdt_run  = !req.idle;
      end
   end
endmodule

// *** hdl/init_value_apply.sv ***
// Per-register initial values for the chosen reset cause.
`timescale 1ns/1ns
module init_value_apply (
   input  reset_init_pkg::cause_t     cause,    // One-hot chosen cause.
   input  reset_init_pkg::reg_image_t cur,      // Present contents.
   output reset_init_pkg::reg_image_t next_img  // Contents after reset.
);
   import reset_init_pkg::*;

   // Bits that keep their contents for this cause.
   function automatic logic [7:0] keep_mask(cause_t c, int i);
      keep_mask = c.wdt_idle ? KEEP_IDLE[i] : BYTE_ZERO;
   endfunction

   // Each register takes forced bits from the table, kept bits from itself.
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         assign next_img[g] = (|cause) ?
            ((cur[g] & keep_mask(cause, g)) |
             (INIT_VAL[g] & ~keep_mask(cause, g))) : cur[g];
      end
   endgenerate
endmodule

// *** hdl/reset_init_ctrl.sv ***
// Reset initial-state controller with a classic Wishbone register slave.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module reset_init_ctrl #(
   parameter int WDT_W = reset_init_pkg::WDT_W_DEF,  // Watchdog width.
   parameter int TB_W  = reset_init_pkg::TB_W_DEF    // Time-base width.
) (
   input  wire logic                        ref_clk,   // System clock.
   input  wire logic                        sys_rst,   // Async reset.
   input  wire logic                        clk_en,    // Freezes when low.
   input  wire reset_init_pkg::reset_req_t  reset_req, // Reset causes.
   input  wire logic [reset_init_pkg::ADR_W-1:0] wb_adr_i, // Address.
   input  wire logic [reset_init_pkg::DAT_W-1:0] wb_dat_i, // Write data.
   input  wire logic [reset_init_pkg::SEL_W-1:0] wb_sel_i, // Lanes.
   input  wire logic                        wb_we_i,   // Write.
   input  wire logic                        wb_cyc_i,  // Cycle.
   input  wire logic                        wb_stb_i,  // Strobe.
   output logic                             wb_ack_o,  // Acknowledge.
   output logic [reset_init_pkg::DAT_W-1:0] wb_dat_o,  // Read data.
   output reset_init_pkg::core_flags_t      core_flags, // Status flags.
   output logic                             lvr_flag,  // Low-voltage flag.
   output reset_init_pkg::reg_image_t       core_regs, // Core registers.
   output logic [WDT_W-1:0]                 wdt_count, // Watchdog count.
   output logic [TB_W-1:0]                  tb_count,  // Time-base count.
   output logic                             irq,       // Interrupt level.
   output logic                             init_done  // Reset applied.
);
   import reset_init_pkg::*;

   localparam logic [WDT_W-1:0] WDT_ZERO = '0;
   localparam logic [WDT_W-1:0] WDT_ONE  = WDT_W'(1);
   localparam logic [TB_W-1:0]  TB_ONE   = TB_W'(1);
   localparam int               WA       = ADR_W - 2;

   // Refuse counter widths that cannot count.
   generate
      if (WDT_W < 2 || TB_W < 2) begin : g_bad_width
         $error("Counter widths must be at least 2");
      end
   endgenerate

   cause_t      cause;
   cause_t      irq_stat;
   cause_t      irq_mask;
   cause_t      next_irq_stat;
   reg_image_t  next_regs;
   logic        bus_req;
   logic        bus_wr;
   logic        core_hit;
   logic [WA-1:0] core_idx;
   logic        wdt_clr_wr;
   logic [DAT_W-1:0] rd_data;

   // Word match of an address against a register offset.
   function automatic logic hit(logic [ADR_W-1:0] a, logic [ADR_W-1:0] o);
      hit = (a[ADR_W-1:2] == o[ADR_W-1:2]);
   endfunction

   reset_cause_pick u_pick (
      .req   (reset_req),
      .cause (cause)
   );

   init_value_apply u_apply (
      .cause    (cause),
      .cur      (core_regs),
      .next_img (next_regs)
   );

   // Bus decode; only the low byte lane carries data.
   assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr   = bus_req & wb_we_i & wb_sel_i[DATA_LANE];
   assign core_idx = wb_adr_i[ADR_W-1:2] - OFS_CORE_BASE[ADR_W-1:2];
   assign core_hit = (wb_adr_i[ADR_W-1:2] >= OFS_CORE_BASE[ADR_W-1:2]) &&
                     (core_idx < WA'(NREG));
   assign wdt_clr_wr = bus_wr & hit(wb_adr_i, OFS_CTRL) &
                       wb_dat_i[WDT_CLR_BIT];
   assign next_irq_stat = (irq_stat & ~((bus_wr &
                           hit(wb_adr_i, OFS_IRQ_STAT)) ?
                           cause_t'(wb_dat_i[$bits(cause_t)-1:0]) :
                           cause_t'('0))) | cause;

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      rd_data = '0;
      if (hit(wb_adr_i, OFS_FLAGS)) begin
         rd_data[FLAG_TO_BIT] = core_flags.timeout_flag;
         rd_data[FLAG_PD_BIT] = core_flags.powerdown_flag;
      end else if (hit(wb_adr_i, OFS_RSTFLAG)) begin
         rd_data[LOW_VOLTAGE_RESET_FLAG_BIT] = lvr_flag;
      end else if (hit(wb_adr_i, OFS_IRQ_STAT)) begin
         rd_data[$bits(cause_t)-1:0] = irq_stat;
      end else if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
         rd_data[$bits(cause_t)-1:0] = irq_mask;
      end else if (core_hit) begin
         rd_data[7:0] = core_regs[core_idx];
      end
   end

   // Single-wait-state acknowledge with registered read data.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (clk_en) begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : '0;
      end
   end

   // Time-out and power-down flags follow the chosen cause.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_flags <= '0;
      end else if (clk_en) begin
         if (cause.por) begin
            core_flags <= '0;
         end else if (cause.wdt_run) begin
            core_flags.timeout_flag <= 1'b1;
         end else if (cause.wdt_idle) begin
            core_flags.timeout_flag   <= 1'b1;
            core_flags.powerdown_flag <= 1'b1;
         end
         // A low-voltage cause leaves both flags as they are.
      end
   end

   // Low-voltage flag: hardware set wins over a software clear.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lvr_flag <= 1'b0;
      end else if (clk_en) begin
         if (cause.low_voltage_reset) begin
            lvr_flag <= 1'b1;
         end else if (bus_wr && hit(wb_adr_i, OFS_RSTFLAG)) begin
            lvr_flag <= lvr_flag & wb_dat_i[LOW_VOLTAGE_RESET_FLAG_BIT];
         end
      end
   end

   // Core registers take table values on a reset, else bus writes.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_regs <= INIT_VAL;
      end else if (clk_en) begin
         if (|cause) begin
            core_regs <= next_regs;
         end else if (bus_wr && core_hit) begin
            core_regs[core_idx] <= wb_dat_i[7:0] & IMPL_MASK[core_idx];
         end
      end
   end

   // Watchdog clears on every cause and on software clear, then counts.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_count <= WDT_ZERO;
      end else if (clk_en) begin
         if ((|cause) || wdt_clr_wr) begin
            wdt_count <= WDT_ZERO;
         end else begin
            wdt_count <= wdt_count + WDT_ONE;
         end
      end
   end

   // Time bases clear on full resets; an idle time-out keeps them.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tb_count <= '0;
      end else if (clk_en) begin
         if (cause.por || cause.low_voltage_reset || cause.wdt_run) begin
            tb_count <= '0;
         end else begin
            tb_count <= tb_count + TB_ONE;
         end
      end
   end

   // Sticky cause events, write-one-to-clear, gated by the mask.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat  <= '0;
         irq_mask  <= '0;
         irq       <= 1'b0;
         init_done <= 1'b0;
      end else if (clk_en) begin
         irq_stat  <= next_irq_stat;
         if (bus_wr && hit(wb_adr_i, OFS_IRQ_MASK)) begin
            irq_mask <= cause_t'(wb_dat_i[$bits(cause_t)-1:0]);
         end
         irq       <= |(next_irq_stat & irq_mask);
         init_done <= |cause;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_por;
      clk_en && reset_req.por;
   endsequence

   sequence s_quiet;
      clk_en && !reset_req.por && !reset_req.low_voltage_reset && !reset_req.wdt &&
      !wdt_clr_wr;
   endsequence

   property p_por_flags;
      s_por |=> !core_flags.timeout_flag && !core_flags.powerdown_flag;
   endproperty
   a_por_flags: assert property (p_por_flags)
      else $error("Flags not cleared by power-on reset");

   property p_lvr_keep;
      clk_en && reset_req.low_voltage_reset && !reset_req.por && !reset_req.idle
         |=> $stable(core_flags);
   endproperty
   a_lvr_keep: assert property (p_lvr_keep)
      else $error("Low-voltage reset changed the flags");

   property p_wdt_run;
      clk_en && reset_req.wdt && !reset_req.idle && !reset_req.por &&
      !reset_req.low_voltage_reset |=> core_flags.timeout_flag &&
      $stable(core_flags.powerdown_flag);
   endproperty
   a_wdt_run: assert property (p_wdt_run)
      else $error("Running time-out flags wrong");

   property p_wdt_idle;
      clk_en && reset_req.wdt && reset_req.idle && !reset_req.por
         |=> core_flags.timeout_flag && core_flags.powerdown_flag &&
             $stable(core_regs[IDX_PA]) && core_regs[IDX_SP] == SP_TOP;
   endproperty
   a_wdt_idle: assert property (p_wdt_idle)
      else $error("Idle time-out state wrong");

   property p_pc_zero;
      clk_en && (|cause) |=> core_regs[IDX_PC_LOW] == BYTE_ZERO;
   endproperty
   a_pc_zero: assert property (p_pc_zero)
      else $error("Program counter not cleared");

   property p_por_core;
      s_por |=> core_regs[IDX_INT] == BYTE_ZERO &&
                core_regs[IDX_TIMER] == BYTE_ZERO &&
                core_regs[IDX_SP] == SP_TOP;
   endproperty
   a_por_core: assert property (p_por_core)
      else $error("Interrupts, timers or stack wrong after power-on");

   property p_ports_in;
      s_por |=> core_regs[IDX_PA_DIR] == INIT_VAL[IDX_PA_DIR] &&
                core_regs[IDX_PB] == INIT_VAL[IDX_PB] &&
                core_regs[IDX_PC_DIR] == INIT_VAL[IDX_PC_DIR];
   endproperty
   a_ports_in: assert property (p_ports_in)
      else $error("Ports not set as inputs");

   property p_wdt_starts;
      s_por ##1 s_quiet |=> wdt_count == WDT_ONE;
   endproperty
   a_wdt_starts: assert property (p_wdt_starts)
      else $error("Watchdog did not restart from zero");

   property p_lvr_flag;
      clk_en && reset_req.low_voltage_reset && !reset_req.por && !reset_req.idle
         |=> lvr_flag [*2];
   endproperty
   a_lvr_flag: assert property (p_lvr_flag)
      else $error("Low-voltage flag not set");

   property p_priority;
      s_por ##0 reset_req.wdt |=> !core_flags.timeout_flag &&
                                  !$rose(lvr_flag);
   endproperty
   a_priority: assert property (p_priority)
      else $error("Power-on did not take priority");
endmodule

// *** test/reset_source_model.sv ***
// Behavioural model of the reset sources that feed the controller.
`timescale 1ns/1ns
module reset_source_model
   import reset_init_pkg::*;
(
   input  wire logic       ref_clk,  // System clock.
   input  wire logic       sys_rst,  // Async reset, active high.
   input  wire logic       fire,     // Bench asks for one event.
   input  wire reset_req_t want,     // Causes of the event.
   output reset_req_t      req       // Requests seen by the controller.
);
   // Each event is held for exactly one cycle, so no cause re-applies.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req <= '0;
      end else begin
         req <= fire ? want : '0;
      end
   end
endmodule

// *** test/reset_init_ctrl_tb_top.sv ***
// Self-checking bench of the reset initial-state controller.
`timescale 1ns/1ns
module reset_init_ctrl_tb_top;
   import reset_init_pkg::*;
   logic                 ref_clk     = 1'b0;
   logic                 sys_rst     = 1'b1;
   logic                 clk_en      = 1'b1;
   logic                 fire        = 1'b0;
   reset_req_t           want        = '0;
   reset_req_t           req;
   logic [ADR_W-1:0]     adr         = '0;
   logic [DAT_W-1:0]     wdat        = '0;
   logic [SEL_W-1:0]     sel         = '0;
   logic                 we          = 1'b0;
   logic                 cyc         = 1'b0;
   logic                 stb         = 1'b0;
   logic                 ack;
   logic [DAT_W-1:0]     rdat;
   core_flags_t          flags;
   logic                 lvr_flag;
   reg_image_t           regs;
   logic [WDT_W_DEF-1:0] wdt_count;
   logic [TB_W_DEF-1:0]  tb_count;
   logic                 irq;
   logic                 init_done;
   logic [DAT_W-1:0]     q;
   reg_image_t           e;
   int                   bad_count   = 0;
   int                   checks_done = 0;

   // Clock of 50 ns period.
   always #25 ref_clk = ~ref_clk;

   reset_source_model SRC (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .fire(fire), .want(want), .req(req));

   reset_init_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .reset_req(req), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .wb_dat_o(rdat), .core_flags(flags),
      .lvr_flag(lvr_flag), .core_regs(regs), .wdt_count(wdt_count),
      .tb_count(tb_count), .irq(irq), .init_done(init_done));

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compares one result, widened to a bus word, with its expected value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      adr  <= a;
      we   <= w;
      wdat <= d;
      sel  <= 4'hF;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 16);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (ack !== 1'b1) begin
         bad_count++;
         conclude();
      end
   endtask

   // Reads a register and compares the word.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(q, exp);
   endtask

   // Sends one reset event and waits, bounded, for the applied pulse.
   task automatic hit(input logic [3:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      want <= reset_req_t'(r);
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (init_done !== 1'b1 && n < 8);
      if (init_done !== 1'b1) begin
         bad_count++;
         conclude();
      end
   endtask

   // Compares every managed register with the expected image.
   task automatic chkregs();
      for (int i = 0; i < NREG; i++) begin
         chk(regs[i], e[i]);
      end
   endtask

   // Main sequence of scenarios.
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(wdt_count, 32'h1);
      chk(tb_count, 32'h1);
      e = INIT_VAL;
      chkregs();
      rd(OFS_FLAGS, 32'h0);
      for (int i = 0; i < NREG; i++) begin
         bus(OFS_CORE_BASE + 8'(4 * i), 1'b1, 32'h5A);
      end
      rd(OFS_CORE_BASE + 8'h24, 32'h5A);
      bus(OFS_IRQ_MASK, 1'b1, 32'h8);
      hit(4'b1100);
      chk(flags, 32'h3);
      for (int i = 0; i < NREG; i++) begin
         e[i] = (i < 2) ? INIT_VAL[i] : 8'h5A;
      end
      chkregs();
      @(posedge ref_clk);
      chk(irq, 32'h1);
      rd(OFS_IRQ_STAT, 32'h8);
      bus(OFS_IRQ_STAT, 1'b1, 32'h8);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h0);
      hit(4'b0010);
      chk(flags, 32'h3);
      chk(lvr_flag, 32'h1);
      e = INIT_VAL;
      chkregs();
      chk(irq, 32'h0);
      bus(OFS_RSTFLAG, 1'b1, 32'h4);
      rd(OFS_RSTFLAG, 32'h4);
      bus(OFS_RSTFLAG, 1'b1, 32'h0);
      rd(OFS_RSTFLAG, 32'h0);
      hit(4'b0001);
      chk(flags, 32'h0);
      chk(wdt_count, 32'h0);
      chk(tb_count, 32'h0);
      @(posedge ref_clk);
      chk(wdt_count, 32'h1);
      chk(tb_count, 32'h1);
      hit(4'b0110);
      chk(flags, 32'h0);
      chk(lvr_flag, 32'h1);
      hit(4'b0100);
      rd(OFS_FLAGS, 32'h1);
      hit(4'b1111);
      chk(flags, 32'h0);
      bus(OFS_FLAGS, 1'b1, 32'h3);
      rd(OFS_FLAGS, 32'h0);
      rd(8'h30, 32'h0);
      bus(OFS_CTRL, 1'b1, 32'h1);
      chk(wdt_count, 32'h0);
      rd(OFS_CTRL, 32'h0);
      // A low enable freezes the counters.
      @(posedge ref_clk);
      clk_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      q = 32'(wdt_count);
      repeat (2) @(posedge ref_clk);
      chk(wdt_count, q);
      clk_en <= 1'b1;
      bus(OFS_IRQ_MASK, 1'b1, 32'hF);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h1);
      bus(OFS_IRQ_STAT, 1'b1, 32'hF);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h0);
      // Port C has no bit 7, so a written one reads back as zero.
      bus(OFS_CORE_BASE + 8'h24, 1'b1, 32'hFF);
      rd(OFS_CORE_BASE + 8'h24, 32'h7F);
      conclude();
   end
endmodule
